/* rtl/sxm_map.svh */
// Offsets, field positions, reset values and timing figures of the expander manager
`ifndef SXM_MAP_SVH
`define SXM_MAP_SVH
`define SXM_NUM_EXP        14
`define SXM_LAST_EXP       4'hd
`define SXM_EXP_RST_A      4'h8
`define SXM_EXP_RST_B      4'hb
`define SXM_EXP_LNK_A      4'hc
`define SXM_EXP_LNK_B      4'hd
`define SXM_EXP_ILK_A      4'h9
`define SXM_EXP_ILK_B      4'ha
`define SXM_REG_IN0        3'h0
`define SXM_REG_OUT0       3'h2
`define SXM_STEP_OUT0      3'h0
`define SXM_STEP_OUT1      3'h1
`define SXM_STEP_INV0      3'h2
`define SXM_STEP_INV1      3'h3
`define SXM_STEP_CFG0      3'h4
`define SXM_STEP_CFG1      3'h5
`define SXM_STEP_IN0       3'h6
`define SXM_STEP_IN1       3'h7
`define SXM_STEP_CMD_OFS   3'h2
`define SXM_INV_NONE       8'h00
`define SXM_CFG_ALL_IN     8'hff
`define SXM_CFG_ALL_OUT    8'h00
`define SXM_CFG_HP         8'h0f
`define SXM_STS_RST        8'h00
`define SXM_UPD_PERIOD_MS  40
`define SXM_CORE_CLK_KHZ   40000
`define SXM_SCL_PERIOD_NS  10000
`define SXM_LINK_CLK_NS    32
`define SXM_SCL_QTR_CYC    ((`SXM_SCL_PERIOD_NS / 4) / `SXM_LINK_CLK_NS)
`define SXM_ACK_BIT        4'h8
`endif

/* rtl/sxm_pkg.sv */
// Types shared by the expander manager modules
package sxm_pkg;
  typedef enum logic [2:0] {
    SXM_S_IDLE  = 3'b000,
    SXM_S_PICK  = 3'b001,
    SXM_S_ISSUE = 3'b010,
    SXM_S_WAIT  = 3'b011,
    SXM_S_NEXT  = 3'b100
  } sxm_state_t;
  typedef enum logic [2:0] {
    SXM_L_IDLE  = 3'b000,
    SXM_L_START = 3'b001,
    SXM_L_BIT   = 3'b010,
    SXM_L_RSTRT = 3'b011,
    SXM_L_STOP  = 3'b100
  } sxm_lstate_t;
  typedef enum logic [1:0] {
    SXM_K_GEN    = 2'b00,
    SXM_K_INONLY = 2'b01,
    SXM_K_LINK   = 2'b10
  } sxm_kind_t;
  typedef struct packed {
    logic [6:0] addr;
    logic [2:0] cmd;
    logic       rd;
    logic [7:0] data;
  } sxm_req_t;
  typedef struct packed {
    logic [7:0] data;
    logic       err;
  } sxm_rsp_t;
endpackage

/* rtl/sxm_sync.sv */
// Two-stage synchroniser with a constant reset value
`timescale 1ns/1ps
module sxm_sync #(
  parameter int unsigned   P_W   = 1,
  parameter logic [P_W-1:0] P_RST = '0
) (
  // Clock and reset
  input  wire logic           i_clk,
  input  wire logic           i_rst_n,
  // Data
  input  wire logic [P_W-1:0] i_d,
  output logic      [P_W-1:0] o_q
);
  logic [P_W-1:0] meta_ff;
  logic [P_W-1:0] q_ff;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_ff <= P_RST;
      q_ff    <= P_RST;
    end else begin
      meta_ff <= i_d;
      q_ff    <= meta_ff;
    end
  end
  assign o_q = q_ff;
endmodule

/* rtl/sxm_smb_link.sv */
// SMBus byte-transaction master on the link clock
`timescale 1ns/1ps
`include "sxm_map.svh"
module sxm_smb_link
  import sxm_pkg::*;
#(
  parameter int unsigned P_SCL_QTR = `SXM_SCL_QTR_CYC
) (
  // Link clock and core reset
  input  wire logic     i_link_clk,
  input  wire logic     i_rst_n,
  // Request from the core, held stable between toggles
  input  wire sxm_req_t i_req,
  input  wire logic     i_req_tgl,
  output sxm_rsp_t      o_rsp,
  output logic          o_ack_tgl,
  // Open-drain SMBus pins
  input  wire logic     i_scl,
  output logic          o_scl_o,
  output logic          o_scl_oe,
  input  wire logic     i_sda,
  output logic          o_sda_o,
  output logic          o_sda_oe
);
  localparam logic [7:0] QTR = 8'(P_SCL_QTR - 1);
  logic        rst_n;
  logic [2:0]  s_w;
  sxm_lstate_t lst_ff;
  sxm_req_t    req_ff;
  sxm_rsp_t    rsp_ff;
  logic [7:0]  div_ff;
  logic [7:0]  sh_ff;
  logic [1:0]  q_ff;
  logic [2:0]  byte_ff;
  logic [3:0]  bit_ff;
  logic        scl_ff, sda_ff, ack_ff, err_ff, seen_ff, tgl_ff;
  sxm_sync #(.P_W(1), .P_RST(1'h0)) u_rst (
    .i_clk(i_link_clk), .i_rst_n(1'b1), .i_d(i_rst_n), .o_q(rst_n)
  );
  sxm_sync #(.P_W(3), .P_RST(3'h3)) u_in (
    .i_clk(i_link_clk), .i_rst_n(rst_n), .i_d({i_req_tgl, i_scl, i_sda}), .o_q(s_w)
  );
  function automatic logic [7:0] byte_val(input logic [2:0] b, input sxm_req_t r);
    case (b)
      3'h0:    byte_val = {r.addr, 1'b0};
      3'h1:    byte_val = {5'h00, r.cmd};
      3'h2:    byte_val = r.data;
      3'h3:    byte_val = {r.addr, 1'b1};
      default: byte_val = 8'hff;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Slave may stretch the clock: the first high quarter waits for a high SCL
  wire       req_evt_w  = s_w[2] != seen_ff;
  wire       stall_w    = (q_ff == 2'h1) & ~s_w[1];
  wire       tick_w     = (div_ff == 8'h00) & ~stall_w;
  wire       last_bit_w = bit_ff == `SXM_ACK_BIT;
  wire       nack_w     = ack_ff & (byte_ff != 3'h4);
  wire [2:0] nxt_byte_w = (lst_ff == SXM_L_RSTRT) ? 3'h3 : (lst_ff == SXM_L_START) ? 3'h0 :
                          (byte_ff == 3'h1 && req_ff.rd) ? 3'h3 : 3'(byte_ff + 3'h1);
  wire [7:0] nxt_tx_w   = byte_val(nxt_byte_w, req_ff);
  always_ff @(posedge i_link_clk) begin
    if (!rst_n || lst_ff == SXM_L_IDLE || div_ff == 8'h00) div_ff <= QTR;
    else div_ff <= 8'(div_ff - 8'h01);
  end
  always_ff @(posedge i_link_clk) begin
    if (!rst_n) begin
      lst_ff <= SXM_L_IDLE;  req_ff <= '0;  rsp_ff <= '0;  sh_ff <= 8'hff;
      q_ff <= 2'h0;  byte_ff <= 3'h0;  bit_ff <= 4'h0;  scl_ff <= 1'b1;  sda_ff <= 1'b1;
      ack_ff <= 1'b0;  err_ff <= 1'b0;  seen_ff <= 1'b0;  tgl_ff <= 1'b0;
    end else if (lst_ff == SXM_L_IDLE) begin
      q_ff <= 2'h0;
      if (req_evt_w) begin
        req_ff  <= i_req;
        seen_ff <= s_w[2];
        err_ff  <= 1'b0;
        lst_ff  <= SXM_L_START;
      end
    end else if (tick_w) begin
      q_ff <= 2'(q_ff + 2'h1);
      case (lst_ff)
        SXM_L_START, SXM_L_RSTRT: begin
          if (q_ff == 2'h0) scl_ff <= 1'b1;
          if (q_ff == 2'h1) sda_ff <= 1'b0;
          if (q_ff == 2'h2) scl_ff <= 1'b0;
          if (q_ff == 2'h3) begin
            lst_ff <= SXM_L_BIT;  byte_ff <= nxt_byte_w;  bit_ff <= 4'h0;
            sh_ff  <= nxt_tx_w;   sda_ff  <= nxt_tx_w[7];
          end
        end
        SXM_L_BIT: begin
          if (q_ff == 2'h0) scl_ff <= 1'b1;
          if (q_ff == 2'h1 && !last_bit_w) sh_ff <= {sh_ff[6:0], s_w[0]};
          if (q_ff == 2'h1 && last_bit_w) ack_ff <= s_w[0];
          if (q_ff == 2'h2) scl_ff <= 1'b0;
          if (q_ff == 2'h3 && !last_bit_w) begin
            bit_ff <= 4'(bit_ff + 4'h1);
            sda_ff <= (bit_ff == 4'h7) ? 1'b1 : sh_ff[7];
          end else if (q_ff == 2'h3) begin
            if (byte_ff == 3'h4) rsp_ff.data <= sh_ff;
            if (nack_w || byte_ff == 3'h2 || byte_ff == 3'h4) begin
              err_ff <= nack_w;  sda_ff <= 1'b0;  lst_ff <= SXM_L_STOP;
            end else if (byte_ff == 3'h1 && req_ff.rd) begin
              sda_ff <= 1'b1;  lst_ff <= SXM_L_RSTRT;
            end else begin
              byte_ff <= nxt_byte_w;  bit_ff <= 4'h0;
              sh_ff   <= nxt_tx_w;    sda_ff <= nxt_tx_w[7];
            end
          end
        end
        SXM_L_STOP: begin
          if (q_ff == 2'h0) scl_ff <= 1'b1;
          if (q_ff == 2'h1) sda_ff <= 1'b1;
          if (q_ff == 2'h3) begin
            rsp_ff.err <= err_ff;  tgl_ff <= ~tgl_ff;  lst_ff <= SXM_L_IDLE;
          end
        end
        default: lst_ff <= SXM_L_IDLE;
      endcase
    end
  end
  assign o_rsp     = rsp_ff;
  assign o_ack_tgl = tgl_ff;
  assign o_scl_o   = 1'b0;
  assign o_sda_o   = 1'b0;
  assign o_scl_oe  = ~scl_ff;
  assign o_sda_oe  = ~sda_ff;
endmodule

/* rtl/sxm_top.sv */
// Expander manager: round scheduler, sequencer and crossing to the SMBus link
`timescale 1ns/1ps
`include "sxm_map.svh"
module sxm_top
  import sxm_pkg::*;
#(
  parameter int unsigned P_UPD_CYC = `SXM_UPD_PERIOD_MS * `SXM_CORE_CLK_KHZ,
  // Quarter bit of the SMBus clock in link cycles; a short value only speeds up simulation
  parameter int unsigned P_SCL_QTR = `SXM_SCL_QTR_CYC
) (
  // Clocks and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_smb_clk,
  // Device control
  input  wire logic              i_exp_en,
  input  wire logic              i_norm_op,
  input  wire logic              i_fund_rst,
  input  wire logic              i_sts_clr,
  // Expander addresses and internal view of outputs
  input  wire logic [13:0][6:0]  i_exp_addr,
  input  wire logic [13:0][15:0] i_hp_out,
  input  wire logic [13:0][15:0] i_port_off,
  input  wire logic [13:0][15:0] i_off_val,
  input  wire logic [7:0]        i_link_up,
  input  wire logic [7:0]        i_link_act,
  // Combined expander interrupt pin
  input  wire logic              i_combined_expander_irq_n,
  // Results and status
  output logic [13:0][15:0]      o_exp_in,
  output logic [13:0]            o_init_done,
  output logic [7:0]             o_smbus_status_reg,
  output logic                   o_busy,
  // SMBus pins
  input  wire logic              i_scl,
  output logic                   o_scl_o,
  output logic                   o_scl_oe,
  input  wire logic              i_sda,
  output logic                   o_sda_o,
  output logic                   o_sda_oe
);
  localparam int unsigned NE  = `SXM_NUM_EXP;
  localparam logic [20:0] TMR = 21'(P_UPD_CYC - 1);
  // Expander kinds decide which steps an initialisation visit runs
  function automatic sxm_kind_t kind_of(input logic [3:0] e);
    if (e == `SXM_EXP_RST_A || e == `SXM_EXP_RST_B) kind_of = SXM_K_INONLY;
    else if (e == `SXM_EXP_LNK_A || e == `SXM_EXP_LNK_B) kind_of = SXM_K_LINK;
    else kind_of = SXM_K_GEN;
  endfunction
  function automatic logic [7:0] cfg_of(input logic [3:0] e, input logic hi);
    case (kind_of(e))
      SXM_K_INONLY: cfg_of = `SXM_CFG_ALL_IN;
      SXM_K_LINK:   cfg_of = `SXM_CFG_ALL_OUT;
      default: begin
        if (e == `SXM_EXP_ILK_A || e == `SXM_EXP_ILK_B) cfg_of = hi ? `SXM_CFG_ALL_OUT : `SXM_CFG_ALL_IN;
        else cfg_of = `SXM_CFG_HP;
      end
    endcase
  endfunction
  sxm_state_t          state_ff, nxt_state;
  sxm_req_t            req_ff;
  sxm_rsp_t            rsp_w;
  logic [3:0]          ptr_ff, vis_ff;
  logic [2:0]          step_ff, last_ff;
  logic                init_ff, rnd_init_ff, rnd_wr_ff, rnd_rd_ff, req_tgl_ff, ack_seen_ff;
  logic [20:0]         wr_tmr_ff, rd_tmr_ff;
  logic [NE-1:0]       init_done_ff;
  logic [NE-1:0][15:0] last_wr_ff, in_ff;
  logic [7:0]          sts_ff;
  logic [NE-1:0][15:0] view_w;
  logic [NE-1:0]       diff_w;
  logic [1:0]          sync_w;
  logic                ack_tgl_w;
  ////////////////////////////////////////////////////////////////////////////
  // Internal view per expander and mismatch against what was last written
  for (genvar g = 0; g < NE; g++) begin : g_view
    wire [15:0] raw_w = (kind_of(4'(g)) == SXM_K_LINK) ? {i_link_act, i_link_up} : i_hp_out[g];
    assign view_w[g] = (raw_w & ~i_port_off[g]) | (i_off_val[g] & i_port_off[g]);
    // Hot reset and bus reset defaults simply appear as a mismatch here
    assign diff_w[g] = (kind_of(4'(g)) != SXM_K_INONLY) && (view_w[g] != last_wr_ff[g]);
  end
  // Interrupt pin and link answer toggle both cross on two flip-flops
  sxm_sync #(.P_W(2), .P_RST(2'h1)) u_sync (
    .i_clk(i_core_clk), .i_rst_n(i_rst_n), .i_d({ack_tgl_w, i_combined_expander_irq_n}), .o_q(sync_w)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Round start and per-expander work
  sxm_kind_t  cur_kind_w;
  assign cur_kind_w = kind_of(ptr_ff);
  wire irq_w       = ~sync_w[0];
  wire ack_evt_w   = sync_w[1] != ack_seen_ff;
  wire need_init_w = |(~init_done_ff);
  wire wr_open_w   = wr_tmr_ff == 21'h000000;
  wire rd_open_w   = rd_tmr_ff == 21'h000000;
  wire init_go_w   = need_init_w & wr_open_w & rd_open_w;
  wire go_w        = i_exp_en & i_norm_op & ~i_fund_rst &
                     (init_go_w | (|diff_w & wr_open_w) | (irq_w & rd_open_w));
  wire do_init_w   = rnd_init_ff & ~init_done_ff[ptr_ff];
  wire do_wr_w     = rnd_wr_ff & diff_w[ptr_ff] & init_done_ff[ptr_ff];
  // A read round reads every initialised expander that has inputs; link expanders have none
  wire do_rd_w     = rnd_rd_ff & (cur_kind_w != SXM_K_LINK) & init_done_ff[ptr_ff];
  wire any_w       = do_init_w | do_wr_w | do_rd_w;
  wire [2:0] first_w = do_init_w ? ((cur_kind_w == SXM_K_INONLY) ? `SXM_STEP_INV0 : `SXM_STEP_OUT0) :
                       do_wr_w ? `SXM_STEP_OUT0 : `SXM_STEP_IN0;
  wire [2:0] last_w  = do_init_w ? ((cur_kind_w == SXM_K_LINK) ? `SXM_STEP_CFG1 : `SXM_STEP_IN1) :
                       (do_wr_w & ~do_rd_w) ? `SXM_STEP_OUT1 : `SXM_STEP_IN1;
  wire [2:0] nxt_step_w = (~init_ff && step_ff == `SXM_STEP_OUT1) ? `SXM_STEP_IN0 : 3'(step_ff + 3'h1);
  wire is_rd_w     = step_ff >= `SXM_STEP_IN0;
  wire is_cfg_w    = (step_ff == `SXM_STEP_CFG0) | (step_ff == `SXM_STEP_CFG1);
  // Output bytes are taken from the live view when the transaction is issued
  wire [7:0] wr_byte_w = (step_ff == `SXM_STEP_OUT0) ? view_w[ptr_ff][7:0] :
                         (step_ff == `SXM_STEP_OUT1) ? view_w[ptr_ff][15:8] :
                         is_cfg_w ? cfg_of(ptr_ff, step_ff[0]) : `SXM_INV_NONE;
  wire done_w      = (state_ff == SXM_S_WAIT) & ack_evt_w;
  wire err_evt_w   = done_w & rsp_w.err;
  wire round_end_w = (state_ff == SXM_S_NEXT) & ((vis_ff == `SXM_LAST_EXP) | i_fund_rst | ~i_exp_en);
  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  // Pick looks at one expander; Next moves the pointer and counts visits
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SXM_S_IDLE:  if (go_w) nxt_state = SXM_S_PICK;
      SXM_S_PICK:  nxt_state = (any_w & ~i_fund_rst) ? SXM_S_ISSUE : SXM_S_NEXT;
      SXM_S_ISSUE: nxt_state = SXM_S_WAIT;
      SXM_S_WAIT: begin
        if (done_w) nxt_state = (rsp_w.err || step_ff == last_ff || i_fund_rst) ? SXM_S_NEXT : SXM_S_ISSUE;
      end
      SXM_S_NEXT:  nxt_state = round_end_w ? SXM_S_IDLE : SXM_S_PICK;
      default:     nxt_state = SXM_S_IDLE;
    endcase
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) state_ff <= SXM_S_IDLE;
    else state_ff <= nxt_state;
  end
  // Pointer keeps rotating over rounds so no expander is favoured
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ptr_ff <= 4'h0;
      vis_ff <= 4'h0;
    end else if (state_ff == SXM_S_IDLE) begin
      vis_ff <= 4'h0;
    end else if (state_ff == SXM_S_NEXT) begin
      ptr_ff <= (ptr_ff == `SXM_LAST_EXP) ? 4'h0 : 4'(ptr_ff + 4'h1);
      vis_ff <= 4'(vis_ff + 4'h1);
    end
  end
  // Round kind is latched once; a change seen later waits for the next slot
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rnd_init_ff <= 1'b0;
      rnd_wr_ff   <= 1'b0;
      rnd_rd_ff   <= 1'b0;
    end else if (state_ff == SXM_S_IDLE && go_w) begin
      rnd_init_ff <= init_go_w;
      rnd_wr_ff   <= wr_open_w & (init_go_w | |diff_w);
      rnd_rd_ff   <= rd_open_w & (init_go_w | irq_w);
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      step_ff <= 3'h0;
      last_ff <= 3'h0;
      init_ff <= 1'b0;
    end else if (state_ff == SXM_S_PICK) begin
      step_ff <= first_w;
      last_ff <= last_w;
      init_ff <= do_init_w;
    end else if (done_w) begin
      step_ff <= nxt_step_w;
    end
  end
  // Spacing restarts when a round ends, so two writes to one expander are a full period apart
  // Timers count core cycles, so P_UPD_CYC must follow the core clock frequency
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) wr_tmr_ff <= 21'h000000;
    else if (round_end_w && rnd_wr_ff) wr_tmr_ff <= TMR;
    else if (!wr_open_w) wr_tmr_ff <= 21'(wr_tmr_ff - 21'h000001);
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) rd_tmr_ff <= 21'h000000;
    else if (round_end_w && rnd_rd_ff) rd_tmr_ff <= TMR;
    else if (!rd_open_w) rd_tmr_ff <= 21'(rd_tmr_ff - 21'h000001);
  end
  ////////////////////////////////////////////////////////////////////////////
  // Request toggle handshake; request word stays still until the answer returns
  // The link copies the request word only after its synchronised toggle moves
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      req_ff     <= '0;
      req_tgl_ff <= 1'b0;
    end else if (state_ff == SXM_S_ISSUE) begin
      req_ff     <= '{addr: i_exp_addr[ptr_ff], cmd: 3'(step_ff + `SXM_STEP_CMD_OFS), rd: is_rd_w, data: wr_byte_w};
      req_tgl_ff <= ~req_tgl_ff;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) ack_seen_ff <= 1'b0;
    else if (ack_evt_w) ack_seen_ff <= sync_w[1];
  end
  // A failed expander leaves the initialised set and is configured again later
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || i_fund_rst) init_done_ff <= '0;
    else if (err_evt_w) init_done_ff[ptr_ff] <= 1'b0;
    else if (done_w && init_ff && step_ff == last_ff) init_done_ff[ptr_ff] <= 1'b1;
  end
  // Expander pins are not reset here; entering reset writes nothing to them
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) last_wr_ff <= '0;
    else if (state_ff == SXM_S_ISSUE && step_ff == `SXM_STEP_OUT0) last_wr_ff[ptr_ff][7:0] <= wr_byte_w;
    else if (state_ff == SXM_S_ISSUE && step_ff == `SXM_STEP_OUT1) last_wr_ff[ptr_ff][15:8] <= wr_byte_w;
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) in_ff <= '0;
    else if (done_w && !rsp_w.err && step_ff == `SXM_STEP_IN0) in_ff[ptr_ff][7:0] <= rsp_w.data;
    else if (done_w && !rsp_w.err && step_ff == `SXM_STEP_IN1) in_ff[ptr_ff][15:8] <= rsp_w.data;
  end
  // Error set wins over a clear in the same cycle
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) sts_ff <= `SXM_STS_RST;
    else if (err_evt_w) sts_ff <= {ptr_ff, 2'h0, req_ff.rd, 1'b1};
    else if (i_sts_clr) sts_ff <= `SXM_STS_RST;
  end
  sxm_smb_link #(.P_SCL_QTR(P_SCL_QTR)) u_link (
    .i_link_clk (i_smb_clk),
    .i_rst_n    (i_rst_n),
    .i_req      (req_ff),
    .i_req_tgl  (req_tgl_ff),
    .o_rsp      (rsp_w),
    .o_ack_tgl  (ack_tgl_w),
    .i_scl      (i_scl),
    .o_scl_o    (o_scl_o),
    .o_scl_oe   (o_scl_oe),
    .i_sda      (i_sda),
    .o_sda_o    (o_sda_o),
    .o_sda_oe   (o_sda_oe)
  );
  assign o_exp_in           = in_ff;
  assign o_init_done        = init_done_ff;
  assign o_smbus_status_reg = sts_ff;
  assign o_busy             = state_ff != SXM_S_IDLE;
  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  wire issue_w = state_ff == SXM_S_ISSUE;
  wr_gate_a: assert property (issue_w && step_ff <= `SXM_STEP_OUT1 |-> wr_tmr_ff == 21'h000000)
    else $error("output write issued inside update period");
  rd_gate_a: assert property (issue_w && is_rd_w |-> rd_tmr_ff == 21'h000000)
    else $error("input read issued inside update period");
  tmr_load_a: assert property (round_end_w && rnd_wr_ff |=> wr_tmr_ff == TMR ##1 wr_tmr_ff == 21'(TMR - 21'h000001))
    else $error("update period not restarted at round end");
  inonly_skip_a: assert property (issue_w && cur_kind_w == SXM_K_INONLY |-> step_ff >= `SXM_STEP_INV0)
    else $error("output register written on input-only expander");
  inonly_cfg_a: assert property (issue_w && cur_kind_w == SXM_K_INONLY && is_cfg_w |-> wr_byte_w == `SXM_CFG_ALL_IN)
    else $error("input-only expander not configured as inputs");
  link_cfg_a: assert property (issue_w && cur_kind_w == SXM_K_LINK |-> !is_rd_w && (!is_cfg_w || wr_byte_w == 8'h00))
    else $error("link expander read or not configured as outputs");
  read_cmd_a: assert property (issue_w && step_ff == `SXM_STEP_IN0 |=> req_ff.rd && req_ff.cmd == `SXM_REG_IN0)
    else $error("input read uses wrong register");
  out_cmd_a: assert property (issue_w && step_ff == `SXM_STEP_OUT0
                              |=> req_ff.cmd == `SXM_REG_OUT0 && req_ff.data == $past(view_w[ptr_ff][7:0]))
    else $error("output byte not taken from live view");
  err_sts_a: assert property (err_evt_w |=> o_smbus_status_reg[0] && o_smbus_status_reg[7:4] == $past(ptr_ff))
    else $error("error not recorded in status");
  fund_quiet_a: assert property (i_fund_rst && state_ff == SXM_S_PICK |=> state_ff != SXM_S_ISSUE)
    else $error("transaction started during fundamental reset");
  irq_read_a: assert property (state_ff == SXM_S_IDLE && go_w && irq_w && rd_open_w |=> rnd_rd_ff)
    else $error("interrupt did not start a read round");
  rr_ptr_a: assert property (state_ff == SXM_S_NEXT && ptr_ff != `SXM_LAST_EXP |=> ptr_ff == $past(ptr_ff) + 4'h1)
    else $error("service pointer skipped");
  init_round_c: cover property (done_w && init_ff && step_ff == `SXM_STEP_IN1 && !rsp_w.err);
  write_round_c: cover property (issue_w && !init_ff && step_ff == `SXM_STEP_OUT1);
  read_round_c: cover property (done_w && !init_ff && step_ff == `SXM_STEP_IN1);
  error_c: cover property (err_evt_w);
  irq_round_c: cover property (state_ff == SXM_S_IDLE && go_w && irq_w);
endmodule

/* bench/sxm_exp_model.sv */
// Behavioural set of SMBus I/O expanders answering 0x20-0x2f
`timescale 1ns/1ps
module sxm_exp_model (
  // Bus levels
  input  wire logic i_scl,
  input  wire logic i_sda,
  // Open-drain drivers
  output logic      o_sda_oe,
  output logic      o_irq_n
);
  logic [7:0] regs [0:127][0:7];
  logic [7:0] sh;
  logic [6:0] adr;
  logic [2:0] ptr;
  logic       rd, pend, act;
  int         cnt, nb, wr_cnt;
  initial begin
    {o_sda_oe, rd, pend, act, cnt, nb, wr_cnt} = '0;
    foreach (regs[a, r]) regs[a][r] = 8'h77;
  end
  assign o_irq_n = ~pend;
  task automatic set_in(input logic [6:0] a, input logic [15:0] v);
    {regs[a][1], regs[a][0]} = v;
    pend = 1;
  endtask
  ////////////////////////////////////////////////////////////////
  always @(negedge i_sda) if (i_scl) {act, cnt, nb} = {1'b1, 64'h0};
  always @(posedge i_sda) if (i_scl) act = 0;
  always @(posedge i_scl) if (act && cnt < 8) begin
    sh = {sh[6:0], i_sda};
    cnt++;
  end
  // Drive only after SCL falls so no false start or stop is seen
  always @(negedge i_scl) if (act) begin
    if (cnt == 9) begin
      cnt = 0;
      nb++;
      o_sda_oe = rd && nb == 1 && !regs[adr][ptr][7];
    end else if (cnt == 8) begin
      cnt = 9;
      o_sda_oe = 1;
      if (nb == 0) {adr, rd, o_sda_oe} = {sh, sh[7:5] == 3'h2};
      else if (rd) {pend, ptr, o_sda_oe} = {pend && ptr != 1, ptr + 3'h1, 1'b0};
      else if (nb == 1) ptr = sh[2:0];
      else {regs[adr][ptr], ptr, wr_cnt} = {sh, ptr + 3'h1, wr_cnt + 1};
    end else if (rd && nb == 1) o_sda_oe = !regs[adr][ptr][7-cnt];
  end
endmodule

/* bench/sxm_top_tb.sv */
// Self-checking bench of the expander manager
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; $display("BAD t=%0t %h %h", $time, g, e); end end
module sxm_top_tb;
  logic              clk = 0, sclk = 0, rst_n = 0, en = 0, nop = 0, frst = 0, clr = 0;
  logic [13:0][6:0]  adr;
  logic [13:0][15:0] hp, off, offv, ein;
  logic [13:0]       idone;
  logic [7:0]        sts;
  logic              scl_oe, sda_oe, m_oe, irq_n, busy;
  wire               scl = ~scl_oe;
  wire               sda = ~(sda_oe | m_oe);
  int                err_total = 0, checks = 0, w0;
  initial forever #12.5 clk = ~clk;
  initial #3 forever #16 sclk = ~sclk;
  sxm_top #(.P_UPD_CYC(200), .P_SCL_QTR(2)) uut (.i_core_clk(clk), .i_rst_n(rst_n), .i_smb_clk(sclk),
    .i_exp_en(en), .i_norm_op(nop), .i_fund_rst(frst), .i_sts_clr(clr), .i_exp_addr(adr), .i_hp_out(hp),
    .i_port_off(off), .i_off_val(offv), .i_link_up(8'ha5), .i_link_act(8'h3c),
    .i_combined_expander_irq_n(irq_n),
    .o_exp_in(ein), .o_init_done(idone), .o_smbus_status_reg(sts), .o_busy(busy), .i_scl(scl),
    .o_scl_o(), .o_scl_oe(scl_oe), .i_sda(sda), .o_sda_o(), .o_sda_oe(sda_oe));
  sxm_exp_model m (.i_scl(scl), .i_sda(sda), .o_sda_oe(m_oe), .o_irq_n(irq_n));
  ////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic t_init();
    {en, nop} = 2'b11;
    for (int i = 0; i < 60000 && idone !== 14'h3fff; i++) #25;
    `CHK(idone, 14'h3fff)
    `CHK(m.regs[7'h28][4], 8'h00)
    `CHK({m.regs[7'h2b][7], m.regs[7'h2b][6], m.regs[7'h2b][5]}, 24'hffff00)
    `CHK(ein[11], 16'hc381)
    `CHK({m.regs[7'h2d][3], m.regs[7'h2c][2]}, 16'h3ca5)
    `CHK({m.regs[7'h2c][4], m.regs[7'h2c][5], m.regs[7'h2c][6], m.regs[7'h2c][7]}, 32'h0)
    `CHK({m.regs[7'h21][3], m.regs[7'h21][2]}, 16'h12f0)
    $display("init end");
  endtask
  // Spacing timer still runs here, so only the second value may go out
  task automatic t_upd();
    w0 = m.wr_cnt;
    hp[3] = 16'h0102;
    @(posedge clk) #1 hp[3] = 16'hbeef;
    for (int i = 0; i < 10000 && m.regs[7'h23][3] !== 8'hbe; i++) #25;
    `CHK({m.regs[7'h23][3], m.regs[7'h23][2]}, 16'hbeef)
    `CHK(m.wr_cnt - w0, 2)
    $display("update end");
  endtask
  task automatic t_irq();
    m.set_in(7'h20, 16'h4d2c);
    m.set_in(7'h29, 16'h9e17);
    for (int i = 0; i < 20000 && {ein[9], ein[0]} !== 32'h9e174d2c; i++) #25;
    `CHK({ein[9], ein[0]}, 32'h9e174d2c)
    `CHK(irq_n, 1'b1)
    $display("irq end");
  endtask
  task automatic t_err();
    clr = 1;
    @(posedge clk) #1 clr = 0;
    {adr[5], hp[5]} = {7'h70, 16'h00aa};
    for (int i = 0; i < 10000 && sts[0] !== 1'b1; i++) #25;
    `CHK(sts, 8'h51)
    $display("error end");
  endtask
  task automatic t_frst();
    frst = 1;
    for (int i = 0; i < 5000 && busy !== 1'b0; i++) #25;
    {w0, hp[2]} = {m.wr_cnt, 16'hffff};
    repeat (2000) #25;
    `CHK({m.wr_cnt - w0, busy, idone}, 47'h0)
    $display("fund reset end");
  endtask
  initial begin
    {hp, off, offv} = '0;
    for (int i = 0; i < 14; i++) adr[i] = 7'h20 + 7'(i);
    {hp[1], off[1], offv[1]} = 48'h1234_00ff_00f0;
    #1 {m.regs[7'h2b][1], m.regs[7'h2b][0]} = 16'hc381;
    // Six core cycles also give the link side four edges of reset
    repeat (6) @(posedge clk);
    #1 rst_n = 1;
    t_init();
    t_upd();
    t_irq();
    t_err();
    t_frst();
    give_verdict();
  end
  initial begin
    #2400000;
    err_total++;
    give_verdict();
  end
endmodule
